/* File: bulk_out_ep2_irq_status.sv */
// Purpose: interrupt source status for bulk OUT endpoint 2
// Assumes: events are one-cycle pulses or levels from the clk_sys domain
// Assumes: firmware never strobes write and read in one cycle
// Notes: status is read-only; cleared by writing 0 to the clear register
// Notes: an event and a clear in one cycle leave the bit set, so no event is lost
// Notes: the interrupt is a one-cycle pulse per unmasked change, not a level
// Notes: the clear register reads back as zero
// Contract
// (R1) any status change raises shared interrupt line; code raises it only for changes to bits whose mask bit is 0
// (R2) status is read-only 8-bit unit
// (R3) firmware reads status to find cause
// (R4) writing 0 to clear bit zeroes status
// (R5) bits invalid when endpoint not mapped
// (R6) both-FIFOs-full set when both hold data
// (R7) full flag zero when SIE FIFO empty
// (R8) full flag cleared on FIFO toggle
// (R9) null packet on empty FIFO sets flag
// (R10) NAK-answered OUT token sets NAK flag
`timescale 1ns/1ps
`default_nettype none
`include "ep2_status_params.svh"
module bulk_out_ep2_irq_status
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire ep2_status_pkg::bus_req_t busReq,
   input wire ep2_status_pkg::ep_events_t epEvents,
   input wire logic ifaceSupportsEp2,
   output logic [7:0] rdData,
   output logic endpointSharedIrqLine
);
   import ep2_status_pkg::*;

   logic [7:0] statusFf;
   logic [7:0] nxt_status;
   logic [7:0] maskFf;
   logic [7:0] mapFf;
   logic [7:0] rdDataFf;
   logic changedFf;
   logic epValid;
   logic clrWr;
   logic [7:0] setBits;

   // an unmapped endpoint must not raise stale causes
   // endpoint usable only when mapped and the interface selects it
   assign epValid = mapFf[`BIT_MAP_EN] & ifaceSupportsEp2; // see (R5)
   assign clrWr = busReq.wr && (busReq.addr == `ADDR_CLEAR);

   // pulses set sticky bits; the null flag needs an empty cpu side
   // event sources; full flag is set from the levels of both FIFOs and cleared by an empty SIE side, a toggle, a clear write or an invalid endpoint
   always_comb
   begin
      setBits = `ZERO_BYTE;
      setBits[`BIT_DONE] = epEvents.doneEvt;
      setBits[`BIT_NAK] = epEvents.nakEvt; // see (R10)
      setBits[`BIT_NULL] = epEvents.nullEvt & ~epEvents.cpuHasData; // see (R9)
      setBits[`BIT_FULL] = epEvents.sieHasData & epEvents.cpuHasData; // see (R6)
   end

   // invalid endpoint overrides everything, so it is applied last
   // sets win over firmware clears so no event is lost
   always_comb
   begin
      nxt_status = statusFf;
      if (clrWr)
      begin
         nxt_status = statusFf & busReq.wdata; // see (R4)
      end
      nxt_status = nxt_status | setBits;
      if (epEvents.fifoToggle || !epEvents.sieHasData)
      begin
         nxt_status[`BIT_FULL] = setBits[`BIT_FULL] & ~epEvents.fifoToggle; // see (R7) see (R8)
      end
      if (!epValid)
      begin
         nxt_status = `RESET_STATUS; // see (R5)
      end
   end

   // from software, the clear register or a map write that unmaps the endpoint can lower a bit
   // status write port has no decode: writes to it are ignored
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         statusFf <= `RESET_STATUS;
      end
      else
      begin
         statusFf <= nxt_status; // see (R2)
      end
   end

   // computed on the next value, so the pulse lines up with the change
   // any unmasked change pulses the shared line for one cycle
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         changedFf <= 1'b0;
      end
      else
      begin
         changedFf <= |((nxt_status ^ statusFf) & ~maskFf); // see (R1)
      end
   end
   assign endpointSharedIrqLine = changedFf;

   // map resets enabled so the endpoint works without setup
   // mask and interface map registers
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         maskFf <= `RESET_MASK;
         mapFf <= `RESET_MAP;
      end
      else
      begin
         if (busReq.wr && busReq.addr == `ADDR_MASK)
         begin
            maskFf <= busReq.wdata;
         end
         if (busReq.wr && busReq.addr == `ADDR_MAP)
         begin
            mapFf <= busReq.wdata;
         end
      end
   end

   // idle zero keeps the shared read bus quiet between reads
   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         rdDataFf <= `ZERO_BYTE;
      end
      else if (busReq.rd)
      begin
         unique case (busReq.addr)
            `ADDR_STATUS: rdDataFf <= statusFf; // see (R3)
            `ADDR_MASK: rdDataFf <= maskFf;
            `ADDR_MAP: rdDataFf <= mapFf;
            default: rdDataFf <= `ZERO_BYTE;
         endcase
      end
      else
      begin
         rdDataFf <= `ZERO_BYTE;
      end
   end
   assign rdData = rdDataFf;

   // bit positions must fit the register; refuse a header that moves them out
   if (`BIT_FULL >= `REG_BITS || `BIT_NULL >= `REG_BITS || `BIT_NAK >= `REG_BITS || `BIT_DONE >= `REG_BITS)
   begin : posCheck
      $error("status bit position outside the register");
   end

   // checks on status, interrupt and read data; the |=> ones judge one cycle after the cause, the interrupt ones the same cycle
   // events are judged against epValid of the same cycle, since that is
   // the value the next-state logic used when it took the event
   // a limitation: the checks see only this block, not the fifo datapath
   // so fifo levels are taken as given inputs

   // a NAK-answered OUT token leaves the NAK flag set
   // set wins over a clear in the same cycle
   nak_sets_a: assert property ( // see (R10)
      @(posedge clk_sys) disable iff (reset)
      epEvents.nakEvt && epValid
      |=> statusFf[`BIT_NAK])
      else $error("nak flag not set");

   // a null packet on an empty cpu side leaves the null flag set
   // with cpu data present the packet is not the cause firmware needs
   null_sets_a: assert property ( // see (R9)
      @(posedge clk_sys) disable iff (reset)
      epEvents.nullEvt && !epEvents.cpuHasData && epValid
      |=> statusFf[`BIT_NULL])
      else $error("null flag not set");

   // both fifos holding data sets the full flag
   // a toggle in the same cycle wins, as it empties one side
   full_sets_a: assert property ( // see (R6)
      @(posedge clk_sys) disable iff (reset)
      epEvents.sieHasData && epEvents.cpuHasData && !epEvents.fifoToggle && epValid
      |=> statusFf[`BIT_FULL])
      else $error("full flag not set");

   // an empty sie side always reads as not full
   // the value straight after reset is not judged, as the check starts once reset is low
   full_clears_a: assert property ( // see (R7)
      @(posedge clk_sys) disable iff (reset)
      !epEvents.sieHasData
      |=> !statusFf[`BIT_FULL])
      else $error("full flag set with empty sie fifo");

   // a fifo toggle drops the full flag
   // the levels may still read full in that cycle
   toggle_clears_a: assert property ( // see (R8)
      @(posedge clk_sys) disable iff (reset)
      epEvents.fifoToggle
      |=> !statusFf[`BIT_FULL])
      else $error("full flag kept over a toggle");

   // each used bit obeys its own clear bit: 0 clears, 1 keeps
   // the event of that bit is excluded, because a set wins over the clear
   for (genvar b = 0; b < `STATUS_BITS; b++)
   begin : clearBit
      clear_works_a: assert property ( // see (R4)
         @(posedge clk_sys) disable iff (reset)
         clrWr && !busReq.wdata[b] && !setBits[b]
         |=> !statusFf[b])
         else $error("clear write ignored");
      clear_keeps_a: assert property ( // see (R4)
         @(posedge clk_sys) disable iff (reset)
         clrWr && busReq.wdata[b] && statusFf[b] && epValid && !epEvents.fifoToggle && epEvents.sieHasData
         |=> statusFf[b])
         else $error("clear write lost a kept bit");
   end

   // an invalid endpoint shows no cause at all
   // firmware would otherwise act on a stale bit
   invalid_zero_a: assert property ( // see (R5)
      @(posedge clk_sys) disable iff (reset)
      !epValid
      |=> statusFf == `RESET_STATUS)
      else $error("status not zero for invalid endpoint");

   // a write aimed at the status register leaves it as it was
   // only cycles without any other cause of change are judged
   status_ro_a: assert property ( // see (R2)
      @(posedge clk_sys) disable iff (reset)
      busReq.wr && busReq.addr == `ADDR_STATUS && setBits == `ZERO_BYTE && !epEvents.fifoToggle
      && epEvents.sieHasData && epValid
      |=> $stable(statusFf))
      else $error("status changed by a write");

   // the unused upper bits always read zero
   unused_zero_a: assert property ( // see (R2)
      @(posedge clk_sys) disable iff (reset)
      (statusFf & ~`STATUS_USED) == `ZERO_BYTE)
      else $error("unused status bit set");

   // a change made while no mask bit was set is announced in the cycle it shows
   // the mask is the one in force when the change was computed
   change_irq_a: assert property ( // see (R1)
      @(posedge clk_sys) disable iff (reset)
      $changed(statusFf) && ($past(maskFf) == `ZERO_BYTE)
      |-> endpointSharedIrqLine)
      else $error("status change without interrupt");

   // the line never pulses without a change to report
   // a spurious pulse would send firmware to an empty register
   irq_cause_a: assert property ( // see (R1)
      @(posedge clk_sys) disable iff (reset)
      endpointSharedIrqLine
      |-> $changed(statusFf))
      else $error("interrupt without status change");

   // a status read returns the value held at the strobe
   // so firmware sees a consistent snapshot of all causes
   rd_status_a: assert property ( // see (R2)
      @(posedge clk_sys) disable iff (reset)
      busReq.rd && busReq.addr == `ADDR_STATUS
      |=> rdData == $past(statusFf))
      else $error("status read returned wrong data");

   // read data are zero outside the answer cycle
   // so the one-cycle window is all a reader can rely on
   rd_idle_a: assert property ( // see (R2)
      @(posedge clk_sys) disable iff (reset)
      !busReq.rd
      |=> rdData == `ZERO_BYTE)
      else $error("read data outside the answer cycle");

   // a completed reception leaves the done flag set
   // same set-wins rule as the other pulses
   done_sets_a: assert property ( // done flag
      @(posedge clk_sys) disable iff (reset)
      epEvents.doneEvt && epValid
      |=> statusFf[`BIT_DONE])
      else $error("done flag not set");

   // main scenarios that the bench is meant to reach
   // null packet flagged
   cover property (@(posedge clk_sys) disable iff (reset) epEvents.nullEvt ##1 statusFf[`BIT_NULL]);
   // full flag set and dropped
   cover property (@(posedge clk_sys) disable iff (reset) statusFf[`BIT_FULL] ##1 !statusFf[`BIT_FULL]);
   // interrupt pulse seen
   cover property (@(posedge clk_sys) disable iff (reset) endpointSharedIrqLine);
   // toggle while full
   cover property (@(posedge clk_sys) disable iff (reset) statusFf[`BIT_FULL] && epEvents.fifoToggle);
   // firmware clear of a set bit
   cover property (@(posedge clk_sys) disable iff (reset) clrWr && (statusFf & ~busReq.wdata) != `ZERO_BYTE);
endmodule // bulk_out_ep2_irq_status
`default_nettype wire

/* File: ep2_status_params.svh */
// Purpose: constants for the bulk OUT endpoint 2 interrupt status block
// Assumes: 8-bit register port, byte addresses as printed
// Notes: definitions only
`ifndef EP2_STATUS_PARAMS_SVH
`define EP2_STATUS_PARAMS_SVH
`define ADDR_STATUS 16'hFF2A
`define ADDR_CLEAR 16'hFF2B
`define ADDR_MASK 16'hFF2C
`define ADDR_MAP 16'hFF2D
`define RESET_STATUS 8'h00
`define RESET_MASK 8'h00
`define RESET_MAP 8'h01
`define BIT_DONE 0
`define BIT_NAK 1
`define BIT_NULL 2
`define BIT_FULL 3
`define BIT_MAP_EN 0
`define STATUS_BITS 4
`define STATUS_USED 8'h0F
`define REG_BITS 8
`define ZERO_BYTE 8'h00
`endif

/* File: ep2_status_pkg.sv */
// Purpose: types shared by the endpoint 2 status block
// Assumes: nothing beyond the params header
// Notes: carrier structs for bus and event groups
package ep2_status_pkg;
   typedef struct packed
   {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed
   {
      logic doneEvt;
      logic nakEvt;
      logic nullEvt;
      logic sieHasData;
      logic cpuHasData;
      logic fifoToggle;
   } ep_events_t;
endpackage

/* File: tb_ep2_status.sv */
// Purpose: self-checking bench for the endpoint 2 status block
// Assumes: mask and map keep reset values unless written
// Notes: waits are fixed by the one-cycle answer, so none is open-ended
`timescale 1ns/1ps
`default_nettype none
`include "ep2_status_params.svh"
module testbench;
   import ep2_status_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   bus_req_t busReq = '0;
   ep_events_t epEvents = '0;
   logic ifaceSupportsEp2 = 1'b1;
   logic [7:0] rdData;
   logic irq;
   int failures = 0;
   int checked = 0;
   bulk_out_ep2_irq_status DUT (.clk_sys(clk_sys), .reset(reset), .busReq(busReq), .epEvents(epEvents),
      .ifaceSupportsEp2(ifaceSupportsEp2), .rdData(rdData), .endpointSharedIrqLine(irq));
   // free-running 10 MHz clock
   initial
   begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want)
      begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   // one-cycle strobe; read data land in the next cycle only
   task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clk_sys);
      busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk_sys);
      busReq <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] want);
      bus(`ADDR_STATUS, 8'h00, 1'b0);
      check(rdData, want);
   endtask
   // order: done, nak, null, sie, cpu, toggle; irq is looked at in its one cycle
   task automatic ev(input ep_events_t v, input logic want);
      @(posedge clk_sys);
      epEvents <= v;
      @(posedge clk_sys);
      epEvents <= '0;
      #1;
      check({7'h00, irq}, {7'h00, want});
   endtask
   task automatic t_flags();
      rd(8'h00);
      bus(`ADDR_STATUS, 8'hFF, 1'b1);
      rd(8'h00);
      ev(6'h10, 1'b1);
      ev(6'h20, 1'b1);
      rd(8'h03);
      bus(`ADDR_CLEAR, 8'hFE, 1'b1);
      rd(8'h02);
      bus(`ADDR_CLEAR, 8'hFD, 1'b1);
      rd(8'h00);
      ev(6'h08, 1'b1);
      rd(8'h04);
      bus(`ADDR_CLEAR, 8'h00, 1'b1);
      bus(`ADDR_MASK, 8'h02, 1'b1);
      ev(6'h10, 1'b0);
      bus(`ADDR_MASK, 8'h00, 1'b1);
      bus(`ADDR_CLEAR, 8'h00, 1'b1);
      ifaceSupportsEp2 <= 1'b0;
      ev(6'h10, 1'b0);
      rd(8'h00);
      ifaceSupportsEp2 <= 1'b1;
      $display("flag tests done");
   endtask
   // mask and map read back; clear register reads zero; unmapped endpoint is silent
   task automatic t_regs();
      bus(`ADDR_MASK, 8'h05, 1'b1);
      bus(`ADDR_MASK, 8'h00, 1'b0);
      check(rdData, 8'h05);
      bus(`ADDR_MASK, 8'h00, 1'b1);
      bus(`ADDR_CLEAR, 8'h00, 1'b0);
      check(rdData, 8'h00);
      bus(`ADDR_MAP, 8'h00, 1'b1);
      ev(6'h10, 1'b0);
      rd(8'h00);
      bus(`ADDR_MAP, 8'h00, 1'b0);
      check(rdData, 8'h00);
      bus(`ADDR_MAP, 8'h01, 1'b1);
      ev(6'h10, 1'b1);
      rd(8'h02);
      bus(`ADDR_CLEAR, 8'h00, 1'b1);
      $display("register tests done");
   endtask
   // levels held across reads; toggle moves SIE data to the CPU side
   task automatic t_full();
      epEvents <= 6'h06;
      rd(8'h08);
      epEvents <= 6'h07;
      @(posedge clk_sys);
      epEvents <= 6'h02;
      rd(8'h00);
      epEvents <= 6'h06;
      rd(8'h08);
      epEvents <= 6'h02;
      rd(8'h00);
      $display("full flag tests done");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // reset held for three cycles, released on an edge
   initial
   begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      t_flags();
      t_regs();
      t_full();
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
